//--- adcs_params.svh
`ifndef ADCS_PARAMS_SVH
`define ADCS_PARAMS_SVH

// ==========================================================
// Register map (byte addresses on the Avalon-MM slave)
`define ADCS_OFF_MODE0 8'h00
`define ADCS_OFF_MODE2 8'h04
`define ADCS_OFF_CHSEL 8'h08
`define ADCS_OFF_PFM 8'h0C
`define ADCS_OFF_PFT 8'h10
`define ADCS_OFF_RES 8'h40
`define ADCS_OFF_RES_END 8'h70

// ==========================================================
// Field positions
`define ADCS_B_EN 0
`define ADCS_B_HW 1
`define ADCS_B_MD_LO 2
`define ADCS_B_MD_HI 3
`define ADCS_B_EF 4
`define ADCS_B_PFE 0
`define ADCS_B_PFC 1

// ==========================================================
// Sizes and reset values
`define ADCS_RES_W 10
`define ADCS_NCH 12
`define ADCS_CH_MAX 4'hB
`define ADCS_MSB_IDX 4'h9
`define ADCS_RST_BYTE 8'h00
`define ADCS_RST_RES 10'h000

// ==========================================================
// Timing: sample window and post-enable stabilization
`define ADCS_CLK_NS 10
`define ADCS_SAMPLE_CYC 4'h8
`define ADCS_STAB_NS 1000
`define ADCS_STAB_CYC ((`ADCS_STAB_NS + `ADCS_CLK_NS - 1) / `ADCS_CLK_NS)

`endif

//--- adcs_pkg.sv
package adcs_pkg;
	// Sequencer states
	typedef enum logic [2:0] {
		ADCS_S_OFF = 3'b000,
		ADCS_S_STAB = 3'b001,
		ADCS_S_WAIT = 3'b010,
		ADCS_S_CONV = 3'b011,
		ADCS_S_HALT = 3'b100
	} adcs_state_type;

	// Operation mode field: bit 0 scan, bit 1 one-shot
	typedef enum logic [1:0] {
		ADCS_MD_CONT_SEL = 2'b00,
		ADCS_MD_CONT_SCAN = 2'b01,
		ADCS_MD_ONE_SEL = 2'b10,
		ADCS_MD_ONE_SCAN = 2'b11
	} adcs_opmode_type;

	// Hardware trigger source select
	typedef enum logic [1:0] {
		ADCS_TRG_EXT = 2'b00,
		ADCS_TRG_TMR0 = 2'b01,
		ADCS_TRG_TMR1 = 2'b10,
		ADCS_TRG_BAD = 2'b11
	} adcs_trig_type;
endpackage : adcs_pkg

//--- adcs_trig.sv
`timescale 1ns/1ps
`default_nettype none
module adcs_trig (
	input wire logic i_mclk,
	input wire logic i_srst,
	input wire logic i_ce,
	input wire adcs_pkg::adcs_trig_type i_sel,
	input wire logic i_match0,
	input wire logic i_match1,
	output logic o_pulse
);
	import adcs_pkg::*;
	logic m0_q;
	logic m1_q;

	// ==========================================================
	// Previous levels for rising-edge detection
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			m0_q <= 1'b0;
			m1_q <= 1'b0;
		end else if (i_ce) begin
			m0_q <= i_match0;
			m1_q <= i_match1;
		end
	end

	// External pin lives elsewhere; 11 is stored in the select register but never fires
	assign o_pulse = (i_sel == ADCS_TRG_TMR0) ? (i_match0 && !m0_q) :
		(i_sel == ADCS_TRG_TMR1) ? (i_match1 && !m1_q) : 1'b0;
endmodule : adcs_trig
`default_nettype wire

//--- adcs_sar.sv
`timescale 1ns/1ps
`default_nettype none
`include "adcs_params.svh"
module adcs_sar #(
	parameter int W = `ADCS_RES_W
) (
	input wire logic i_mclk,
	input wire logic i_srst,
	input wire logic i_ce,
	input wire logic i_start,
	input wire logic i_abort,
	input wire logic i_cmp_ge,
	output logic o_sample,
	output logic [W-1:0] o_trial,
	output logic o_done,
	output logic [W-1:0] o_result
);
	import adcs_pkg::*;
	logic [3:0] cnt_q;
	logic [3:0] bit_q;
	logic busy_q;
	logic [W-1:0] kept;

	function automatic logic [W-1:0] onehot(input logic [3:0] b);
		onehot = {{(W-1){1'b0}}, 1'b1} << b;
	endfunction : onehot

	// Trial bit survives only when the input is at or above the tap
	assign kept = i_cmp_ge ? o_trial : (o_trial & ~onehot(bit_q));

	// ==========================================================
	// Sample, then one comparison per clock from MSB down
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			cnt_q <= 4'h0;
			bit_q <= 4'h0;
			busy_q <= 1'b0;
			o_sample <= 1'b0;
			o_trial <= '0;
			o_done <= 1'b0;
			o_result <= '0;
		end else if (i_ce) begin
			o_done <= 1'b0;
			if (i_start) begin // A start also restarts a running conversion
				o_sample <= 1'b1;
				cnt_q <= `ADCS_SAMPLE_CYC;
				busy_q <= 1'b0;
				o_trial <= '0;
			end else if (i_abort) begin
				o_sample <= 1'b0;
				busy_q <= 1'b0;
			end else if (o_sample) begin
				cnt_q <= cnt_q - 4'h1;
				if (cnt_q == 4'h1) begin
					o_sample <= 1'b0;
					busy_q <= 1'b1;
					bit_q <= `ADCS_MSB_IDX;
					o_trial <= onehot(`ADCS_MSB_IDX);
				end
			end else if (busy_q) begin
				if (bit_q == 4'h0) begin
					busy_q <= 1'b0;
					o_done <= 1'b1;
					o_result <= kept;
					o_trial <= kept;
				end else begin
					bit_q <= bit_q - 4'h1;
					o_trial <= kept | onehot(bit_q - 4'h1);
				end
			end
		end
	end
endmodule : adcs_sar
`default_nettype wire

//--- adcs_top.sv
// The register addresses and the Avalon-MM interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "adcs_params.svh"
// What this block does
// - Timer trigger starts on compare-match rising edge
// - Source select: 01 timer0, 10 timer1; 00 (pin) and 11 never fire here
// - Hardware mode waits for trigger after enable
// - Each completion stores, signals end, re-waits
// - Active flag high converting, low while waiting
// - Trigger during conversion restarts it
// - Config write during conversion: hardware mode returns to waiting, software mode restarts
// - Four operation modes via two-bit field
// - Continuous select repeats one channel
// - Continuous scan runs 0..selected, then repeats
// - One-shot select converts once then stops
// - One-shot scan runs 0..selected once
// - Compare off: end event at normal point
// - Polarity 0: end only if upper byte >= threshold
// - Polarity 1: end only if upper byte < threshold
// - Result always stored; only end event suppressed
// - Ten-bit result moved into channel register
// - Software mode starts on enable at once
module adcs_top #(
	parameter int NCH = `ADCS_NCH
) (
	input wire logic i_mclk,
	input wire logic i_srst,
	input wire logic i_ce,
	input wire logic [7:0] i_address,
	input wire logic i_read,
	input wire logic i_write,
	input wire logic [31:0] i_writedata,
	input wire logic [3:0] i_byteenable,
	output logic [31:0] o_readdata,
	output logic o_waitrequest,
	input wire logic i_timer_match_event_0,
	input wire logic i_timer_match_event_1,
	input wire logic i_cmp_ge,
	output logic o_sample,
	output logic [`ADCS_RES_W-1:0] o_sar_trial,
	output logic [3:0] o_analog_chan,
	output logic o_conversion_end_event,
	output logic o_conversion_active_flag
);
	import adcs_pkg::*;

	localparam int STAB_CYC = `ADCS_STAB_CYC;
	localparam logic [7:0] PFT_RST = `ADCS_RST_BYTE;

	adcs_state_type state_q, state_d;
	logic en_q, hw_q;
	adcs_opmode_type md_q;
	adcs_trig_type tsel_q;
	logic [3:0] chsel_q, ch_q, ch_d;
	logic pfe_q, pfc_q, pfok_q, pfok_d;
	logic [7:0] pft_q;
	logic [15:0] stab_q, stab_d;
	logic [`ADCS_RES_W-1:0] res_q [NCH];
	logic go_d, go_q, abort_q, end_d, wr_res;
	logic sar_done;
	logic [`ADCS_RES_W-1:0] sar_res;
	logic trig;

	// ==========================================================
	// Bus decode: a request is served on the cycle waitrequest is low
	wire req = i_read || i_write;
	wire wr_fire = i_write && !o_waitrequest && i_byteenable[0];
	wire w_mode0 = wr_fire && (i_address == `ADCS_OFF_MODE0);
	wire w_mode2 = wr_fire && (i_address == `ADCS_OFF_MODE2);
	wire w_chsel = wr_fire && (i_address == `ADCS_OFF_CHSEL);
	wire w_pfm = wr_fire && (i_address == `ADCS_OFF_PFM);
	wire w_pft = wr_fire && (i_address == `ADCS_OFF_PFT);
	wire cfg_wr = w_mode2 || w_chsel || w_pfm || w_pft;
	wire new_en = i_writedata[`ADCS_B_EN];
	wire hw_eff = w_mode0 ? i_writedata[`ADCS_B_HW] : hw_q;
	wire [1:0] md_eff = w_mode0 ? i_writedata[`ADCS_B_MD_HI:`ADCS_B_MD_LO] : md_q;
	wire [3:0] chsel_eff = w_chsel ? clamp_ch(i_writedata[3:0]) : chsel_q;
	wire is_res = (i_address >= `ADCS_OFF_RES) && (i_address < `ADCS_OFF_RES_END);
	wire [7:0] res_off = i_address - `ADCS_OFF_RES;
	wire [3:0] res_idx = res_off[5:2];

	// Channel numbers above the last input are pinned to the last one
	function automatic logic [3:0] clamp_ch(input logic [3:0] c);
		clamp_ch = (c > `ADCS_CH_MAX) ? `ADCS_CH_MAX : c;
	endfunction : clamp_ch

	// Scan modes begin at channel 0, select modes at the chosen one
	function automatic logic [3:0] first_ch(input logic [1:0] md, input logic [3:0] sel);
		first_ch = md[0] ? 4'h0 : sel;
	endfunction : first_ch

	// ==========================================================
	// Comparison on the conversion just finished
	wire [7:0] res_hi = sar_res[`ADCS_RES_W-1:`ADCS_RES_W-8];
	wire cmp_hit = pfc_q ? (res_hi < pft_q) : (res_hi >= pft_q);
	wire ok_now = !pfe_q || cmp_hit;
	wire ok_seq = (ch_q == 4'h0) ? ok_now : pfok_q;
	wire scan = md_q[0];
	wire last = !scan || (ch_q >= chsel_q);

	// ==========================================================
	// Read mux
	wire [31:0] rd_word =
		(i_address == `ADCS_OFF_MODE0) ? {27'h0, o_conversion_active_flag, md_q, hw_q, en_q} :
		(i_address == `ADCS_OFF_MODE2) ? {30'h0, tsel_q} :
		(i_address == `ADCS_OFF_CHSEL) ? {28'h0, chsel_q} :
		(i_address == `ADCS_OFF_PFM) ? {30'h0, pfc_q, pfe_q} :
		(i_address == `ADCS_OFF_PFT) ? {24'h0, pft_q} :
		(is_res && res_idx < NCH[3:0]) ? {22'h0, res_q[res_idx]} : 32'h0;

	// ==========================================================
	// Sequencer next state; bus writes take priority over engine events
	always_comb begin
		state_d = state_q;
		ch_d = ch_q;
		go_d = 1'b0;
		stab_d = stab_q;
		end_d = 1'b0;
		pfok_d = pfok_q;
		wr_res = 1'b0;
		if (w_mode0 && !new_en) begin
			state_d = ADCS_S_OFF;
		end else if (w_mode0 && hw_eff && (state_q == ADCS_S_OFF || state_q == ADCS_S_HALT)) begin
			state_d = ADCS_S_STAB;
			stab_d = STAB_CYC[15:0];
		end else if ((w_mode0 || (cfg_wr && state_q == ADCS_S_CONV)) && !hw_eff) begin
			state_d = ADCS_S_CONV;
			go_d = 1'b1;
			ch_d = first_ch(md_eff, chsel_eff);
		end else if ((w_mode0 || cfg_wr) && state_q == ADCS_S_CONV) begin
			state_d = ADCS_S_WAIT;
		end else begin
			case (state_q)
				ADCS_S_STAB: begin
					if (stab_q == 16'h0) begin
						state_d = ADCS_S_WAIT;
					end else begin
						stab_d = stab_q - 16'h1;
					end
				end
				ADCS_S_WAIT: begin
					if (trig) begin
						state_d = ADCS_S_CONV;
						go_d = 1'b1;
						ch_d = first_ch(md_q, chsel_q);
					end
				end
				ADCS_S_CONV: begin
					if (trig && hw_q) begin
						go_d = 1'b1;
						ch_d = first_ch(md_q, chsel_q);
					end else if (sar_done) begin
						wr_res = 1'b1;
						if (ch_q == 4'h0) begin
							pfok_d = ok_now;
						end
						if (!last) begin
							go_d = 1'b1;
							ch_d = ch_q + 4'h1;
						end else begin
							end_d = scan ? ok_seq : ok_now;
							if (hw_q) begin
								state_d = ADCS_S_WAIT;
							end else if (md_q[1]) begin
								state_d = ADCS_S_HALT;
							end else begin
								go_d = 1'b1;
								ch_d = first_ch(md_q, chsel_q);
							end
						end
					end
				end
				default: begin
				end
			endcase
		end
	end

	// ==========================================================
	// Bus slave: one wait cycle, then the answer stands for one cycle
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			o_waitrequest <= 1'b1;
			o_readdata <= 32'h0;
		end else if (i_ce) begin
			o_waitrequest <= !(req && o_waitrequest);
			o_readdata <= rd_word;
		end
	end

	// ==========================================================
	// Software-visible configuration
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			en_q <= 1'b0;
			hw_q <= 1'b0;
			md_q <= ADCS_MD_CONT_SEL;
			tsel_q <= ADCS_TRG_EXT;
			chsel_q <= 4'h0;
			pfe_q <= 1'b0;
			pfc_q <= 1'b0;
			pft_q <= PFT_RST;
		end else if (i_ce) begin
			if (w_mode0) begin
				en_q <= new_en;
				hw_q <= i_writedata[`ADCS_B_HW];
				md_q <= adcs_opmode_type'(i_writedata[`ADCS_B_MD_HI:`ADCS_B_MD_LO]);
			end
			if (w_mode2) tsel_q <= adcs_trig_type'(i_writedata[1:0]);
			if (w_chsel) chsel_q <= chsel_eff;
			if (w_pfm) begin
				pfe_q <= i_writedata[`ADCS_B_PFE];
				pfc_q <= i_writedata[`ADCS_B_PFC];
			end
			if (w_pft) pft_q <= i_writedata[7:0];
		end
	end

	// ==========================================================
	// Sequencer state, engine strobes and result store
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			state_q <= ADCS_S_OFF;
			ch_q <= 4'h0;
			stab_q <= 16'h0;
			pfok_q <= 1'b0;
			go_q <= 1'b0;
			abort_q <= 1'b0;
			o_conversion_end_event <= 1'b0;
			o_conversion_active_flag <= 1'b0;
			for (int i = 0; i < NCH; i++) res_q[i] <= `ADCS_RST_RES;
		end else if (i_ce) begin
			state_q <= state_d;
			ch_q <= ch_d;
			stab_q <= stab_d;
			pfok_q <= pfok_d;
			go_q <= go_d;
			abort_q <= (state_q == ADCS_S_CONV) && (state_d != ADCS_S_CONV);
			o_conversion_end_event <= end_d;
			o_conversion_active_flag <= (state_d == ADCS_S_CONV);
			if (wr_res && ch_q < NCH[3:0]) res_q[ch_q] <= sar_res;
		end
	end

	assign o_analog_chan = ch_q;

	adcs_trig u_trig (
		.i_mclk(i_mclk),
		.i_srst(i_srst),
		.i_ce(i_ce),
		.i_sel(tsel_q),
		.i_match0(i_timer_match_event_0),
		.i_match1(i_timer_match_event_1),
		.o_pulse(trig)
	);

	adcs_sar #(.W(`ADCS_RES_W)) u_sar (
		.i_mclk(i_mclk),
		.i_srst(i_srst),
		.i_ce(i_ce),
		.i_start(go_q),
		.i_abort(abort_q),
		.i_cmp_ge(i_cmp_ge),
		.o_sample(o_sample),
		.o_trial(o_sar_trial),
		.o_done(sar_done),
		.o_result(sar_res)
	);

	// ==========================================================
	// Checks
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_srst || !i_ce);

	sequence trig_in_wait;
		state_q == ADCS_S_WAIT && trig && !w_mode0 && !cfg_wr;
	endsequence
	sequence engine_starts;
		go_q ##1 o_sample;
	endsequence

	wait_idle_a: assert property (state_q == ADCS_S_WAIT |-> !o_conversion_active_flag)
		else $error("active flag high while waiting");
	trig_start_a: assert property (trig_in_wait |=> o_conversion_active_flag and engine_starts)
		else $error("trigger did not start conversion");
	stab_hold_a: assert property (state_q == ADCS_S_STAB && !w_mode0 |=> !go_q)
		else $error("conversion began during stabilization");
	retrig_a: assert property (state_q == ADCS_S_CONV && hw_q && trig && !w_mode0 && !cfg_wr
		|=> go_q && ch_q == first_ch(md_q, chsel_q))
		else $error("trigger during conversion did not restart");
	cfg_stop_a: assert property (state_q == ADCS_S_CONV && hw_q && cfg_wr
		|=> state_q == ADCS_S_WAIT && !o_conversion_active_flag)
		else $error("config write did not stop conversion");
	result_store_a: assert property (sar_done && state_q == ADCS_S_CONV && !trig && !w_mode0
		&& !cfg_wr && ch_q < NCH[3:0] |=> res_q[$past(ch_q)] == $past(sar_res))
		else $error("result not stored in its channel");
	sel_end_a: assert property (sar_done && state_q == ADCS_S_CONV && !scan && !pfe_q && !trig
		&& !w_mode0 && !cfg_wr |=> o_conversion_end_event)
		else $error("missing end event in select mode");
	pf_ge_a: assert property (sar_done && !scan && pfe_q && !pfc_q && res_hi < pft_q
		|=> !o_conversion_end_event)
		else $error("end event despite failed >= compare");
	pf_lt_a: assert property (sar_done && !scan && pfe_q && pfc_q && res_hi >= pft_q
		|=> !o_conversion_end_event)
		else $error("end event despite failed < compare");
	oneshot_halt_a: assert property (sar_done && state_q == ADCS_S_CONV && !hw_q && md_q[1] && last
		&& !w_mode0 && !cfg_wr |=> state_q == ADCS_S_HALT ##1 !go_q)
		else $error("one-shot did not stop");
	sw_start_a: assert property (w_mode0 && new_en && !i_writedata[`ADCS_B_HW]
		|=> engine_starts)
		else $error("software enable did not start conversion");
endmodule : adcs_top
`default_nettype wire

//--- adcs_analog_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Analog inputs and comparator that face the converter
module adcs_analog_model (
	input wire logic i_mclk,
	input wire logic i_sample,
	input wire logic [3:0] i_chan,
	input wire logic [9:0] i_trial,
	output logic o_cmp_ge
);
	logic [9:0] lvl [0:11];
	logic [9:0] held_q;
	// Track the input only while sampling; the hold keeps bit trials steady
	always_ff @(posedge i_mclk) begin
		if (i_sample) begin
			held_q <= lvl[i_chan];
		end
	end
	// Ties compare high, so an ideal search lands on the held level
	assign o_cmp_ge = (held_q >= i_trial);
endmodule : adcs_analog_model
`default_nettype wire

//--- adc_trigger_mode_sequencer_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "adcs_params.svh"
module adc_trigger_mode_sequencer_bench;
	import adcs_pkg::*;
	logic mclk, srst, rd_s, wr_s, tm0, tm1, cmp, smp, wait_r, endp, act;
	logic [7:0] adr;
	logic [31:0] wd, rdat, got;
	logic [9:0] trial;
	logic [3:0] chan;
	logic [9:0] lvl [0:11];
	int errors, check_count, ends, e0, cnt;

	adcs_top uut (.i_mclk(mclk), .i_srst(srst), .i_ce(1'b1), .i_address(adr),
		.i_read(rd_s), .i_write(wr_s), .i_writedata(wd), .i_byteenable(4'h1),
		.o_readdata(rdat), .o_waitrequest(wait_r), .i_timer_match_event_0(tm0),
		.i_timer_match_event_1(tm1), .i_cmp_ge(cmp), .o_sample(smp), .o_sar_trial(trial),
		.o_analog_chan(chan), .o_conversion_end_event(endp), .o_conversion_active_flag(act));
	adcs_analog_model far (.i_mclk(mclk), .i_sample(smp), .i_chan(chan), .i_trial(trial),
		.o_cmp_ge(cmp));

	// ==========================================================
	// Clock, end-event counter and watchdog
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	always @(posedge mclk) if (endp === 1'b1) ends <= ends + 1;
	// Longest run is near 6k cycles, so this only trips on a hang
	initial begin
		#500_000;
		errors++;
		summarize;
	end

	// ==========================================================
	// Shared tasks
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task summarize;
		$display("errors=%0d checks=%0d", errors, check_count);
		if (errors == 0 && check_count > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : summarize
	// Avalon cycle: hold everything until waitrequest is sampled low
	task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		adr <= a;
		wd <= {24'h00_0000, d};
		rd_s <= !w;
		wr_s <= w;
		do @(posedge mclk); while (wait_r !== 1'b0);
		got = rdat;
		rd_s <= 1'b0;
		wr_s <= 1'b0;
	endtask : bus
	task setlvl(input int ch, input logic [9:0] v);
		lvl[ch] = v;
		far.lvl[ch] = v;
	endtask : setlvl
	// Match events are levels; only the rising edge counts
	task trig(input logic which);
		@(posedge mclk);
		if (which) tm1 <= 1'b1;
		else tm0 <= 1'b1;
		repeat (2) @(posedge mclk);
		tm0 <= 1'b0;
		tm1 <= 1'b0;
	endtask : trig
	// Select modes touch one register, scan modes 0..ch
	task chk_res(input logic [1:0] md, input int ch);
		for (int i = 0; i <= ch; i++) begin
			if (md[0] || i == ch) begin
				bus(1'b0, 8'(`ADCS_OFF_RES + 4 * i), 8'h00);
				chk(got, {22'h00_0000, lvl[i]});
			end
		end
	endtask : chk_res
	// Software start; want 2 means at least two end events
	task sw_run(input logic [1:0] md, input int ch, input logic [7:0] pfm,
		input logic [7:0] pft, input int want);
		bus(1'b1, `ADCS_OFF_CHSEL, 8'(ch));
		bus(1'b1, `ADCS_OFF_PFM, pfm);
		bus(1'b1, `ADCS_OFF_PFT, pft);
		e0 = ends;
		bus(1'b1, `ADCS_OFF_MODE0, {4'h0, md, 2'b01});
		repeat (300) @(posedge mclk);
		bus(1'b1, `ADCS_OFF_MODE0, 8'h00);
		repeat (3) @(posedge mclk);
		cnt = ends - e0;
		if (want == 2) chk(32'(cnt >= 2), 32'h1);
		else chk(32'(cnt), 32'(want));
		chk_res(md, ch);
	endtask : sw_run
	// Hardware trigger setup; waits out stabilization before any event
	task hw_on(input logic [1:0] md, input int ch, input logic src);
		bus(1'b1, `ADCS_OFF_MODE0, 8'h00);
		bus(1'b1, `ADCS_OFF_MODE2, {6'h00, src, !src});
		bus(1'b1, `ADCS_OFF_CHSEL, 8'(ch));
		bus(1'b1, `ADCS_OFF_PFM, 8'h00);
		bus(1'b1, `ADCS_OFF_MODE0, {4'h0, md, 2'b11});
		repeat (`ADCS_STAB_CYC + 4) @(posedge mclk);
	endtask : hw_on

	// ==========================================================
	// Main sequence
	initial begin
		srst = 1'b1;
		rd_s = 1'b0;
		wr_s = 1'b0;
		adr = 8'h00;
		wd = 32'h0000_0000;
		tm0 = 1'b0;
		tm1 = 1'b0;
		errors = 0;
		check_count = 0;
		ends = 0;
		cnt = $urandom(39);
		for (int i = 0; i < 12; i++) setlvl(i, 10'($urandom));
		repeat (5) @(posedge mclk);
		srst <= 1'b0;
		// Reset value, unmapped read, write to a read-only result
		bus(1'b0, `ADCS_OFF_MODE0, 8'h00);
		chk(got, 32'h0000_0000);
		bus(1'b0, 8'h20, 8'h00);
		chk(got, 32'h0000_0000);
		bus(1'b1, `ADCS_OFF_RES, 8'hFF);
		bus(1'b0, `ADCS_OFF_RES, 8'h00);
		chk(got, 32'h0000_0000);
		// Software start in all four modes, compare off
		for (int m = 0; m < 4; m++) sw_run(m[1:0], 2, 8'h00, 8'h00, m[1] ? 1 : 2);
		// Threshold at and just above the upper byte, both polarities
		setlvl(1, {8'($urandom % 255), 2'b00});
		for (int k = 0; k < 4; k++) begin
			setlvl(1, {lvl[1][9:2], 2'($urandom)});
			sw_run(2'b00, 1, {6'h00, k[1], 1'b1}, lvl[1][9:2] + 8'(k[0]),
				(k[1] ^ k[0]) ? 0 : 2);
		end
		// Timer triggers in every mode, both sources
		for (int m = 0; m < 4; m++) begin
			hw_on(m[1:0], 2, m[0]);
			e0 = ends;
			trig(!m[0]);
			repeat (3) @(posedge mclk);
			chk({31'h0, act}, 32'h1 ^ 32'h1);
			repeat (2) begin
				trig(m[0]);
				@(posedge mclk);
				chk({31'h0, act}, 32'h1);
				repeat (250) @(posedge mclk);
				chk({31'h0, act}, 32'h0);
			end
			chk(32'(ends - e0), 32'h2);
			chk_res(m[1:0], 2);
		end
		// A second trigger mid-conversion starts over
		hw_on(2'b00, 5, 1'b0);
		e0 = ends;
		trig(1'b0);
		repeat (8) @(posedge mclk);
		trig(1'b0);
		cnt = 0;
		while (ends == e0 && cnt < 100) begin
			@(posedge mclk);
			cnt++;
		end
		chk(32'(cnt > 14), 32'h1);
		repeat (100) @(posedge mclk);
		chk(32'(ends - e0), 32'h1);
		// Config write mid-conversion drops back to waiting
		e0 = ends;
		trig(1'b0);
		repeat (5) @(posedge mclk);
		bus(1'b1, `ADCS_OFF_CHSEL, 8'h03);
		repeat (100) @(posedge mclk);
		chk(32'(ends - e0), 32'h0);
		chk({31'h0, act}, 32'h0);
		trig(1'b0);
		repeat (60) @(posedge mclk);
		chk(32'(ends - e0), 32'h1);
		chk_res(2'b00, 3);
		summarize;
	end
endmodule : adc_trigger_mode_sequencer_bench
`default_nettype wire
